// [pkg/svwdr_pkg.sv]
// Package with timing constants and state encodings for the supervisory watchdog reset block.
`default_nettype none
package svwdr_pkg;
  // Clock rate in kHz and period in ps.
  localparam int CLOCK_KHZ = 200000;
  localparam int CLOCK_PS = 5000;
  // Manual reset glitch rejection time in ns (shorter low pulses are ignored).
  localparam int MR_GLITCH_NS = 100;
  localparam int MR_GLITCH_CYCLES = (MR_GLITCH_NS * 1000 + CLOCK_PS - 1) / CLOCK_PS;
  // Shortest kick pulse that must be seen, in ns.
  localparam int KICK_MIN_NS = 50;
  localparam int KICK_MIN_CYCLES = (KICK_MIN_NS * 1000) / CLOCK_PS;
  // Supply dip rejection time in ns.
  localparam int DIP_REJECT_NS = 4000;
  localparam int DIP_REJECT_CYCLES = (DIP_REJECT_NS * 1000 + CLOCK_PS - 1) / CLOCK_PS;
  // Active pull-up one-shot in ns.
  localparam int PULLUP_SHOT_NS = 2000;
  localparam int PULLUP_SHOT_CYCLES = (PULLUP_SHOT_NS * 1000) / CLOCK_PS;
  // Default watchdog period 1.6 s and reset hold 140 ms, in microseconds.
  localparam longint WATCHDOG_PERIOD_US = 1600000;
  localparam longint RESET_HOLD_US = 140000;
  localparam longint WATCHDOG_PERIOD_CYCLES = (WATCHDOG_PERIOD_US * CLOCK_KHZ) / 1000;
  localparam longint RESET_HOLD_CYCLES = (RESET_HOLD_US * CLOCK_KHZ + 999) / 1000;
  // Width of the long timers.
  localparam int TIMER_W = 32;
  // Output stage selection.
  localparam logic [1:0] STAGE_PP_LOW = 2'h0;
  localparam logic [1:0] STAGE_PP_HIGH = 2'h1;
  localparam logic [1:0] STAGE_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] STAGE_BIDIR = 2'h3;
  // Reset sequencer states.
  typedef enum logic [1:0] {
    SVWDR_ASSERT = 2'b00,
    SVWDR_HOLD = 2'b01,
    SVWDR_RUN = 2'b10
  } svwdr_state_t;
endpackage : svwdr_pkg
`default_nettype wire

// [src/svwdr_filter.sv]
// Three-stage pin synchroniser with a minimum-duration level filter.
`timescale 1ns/1ps
`default_nettype none
module svwdr_filter #(
  parameter int CYCLES = 1,
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_pin,
  output logic o_level,
  output logic o_change
);
  logic [2:0] sync;
  logic [15:0] count;

  // Three flops; only the last two are compared.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync <= {3{RESET_LEVEL}};
    end else begin
      sync <= {sync[1:0], i_pin};
    end
  end

  // A new level is accepted only after it has stood for CYCLES agreeing samples.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_level <= RESET_LEVEL;
      o_change <= 1'b0;
      count <= 16'h0000;
    end else begin
      o_change <= 1'b0;
      if (sync[2] != sync[1] || sync[2] == o_level) begin
        count <= 16'h0000;
      end else if (count >= 16'(CYCLES - 1)) begin
        o_level <= sync[2];
        o_change <= 1'b1;
        count <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule : svwdr_filter
`default_nettype wire

// [src/svwdr_top.sv]
// Supervisory reset block: manual reset, watchdog, supply monitor and reset output stage.
//
// Overview of operation
// RULE1: Reset is asserted while the manual reset input is held low.
// RULE2: After manual reset rises, reset stays asserted for the full hold period.
// RULE3: Manual reset lows shorter than about 100 ns are ignored.
// RULE4: If the kick input does not change within the watchdog period, reset is asserted.
// RULE5: Any kick edge of 50 ns or longer clears the watchdog timer, as does any reset; the code needs the new kick level for 11 samples, about 55 ns.
// RULE6: The watchdog timer stays cleared during reset and counts only after release.
// RULE7: A floating kick input is serviced internally every seven eighths of the watchdog period.
// RULE8: The host disables the watchdog by leaving the kick input undriven.
// RULE9: The bidirectional active pull-up works for every reset source, including external pull-down.
// RULE10: The bidirectional line is driven back high quickly after release.
// RULE11: The passive pull-up is disconnected while the block itself asserts reset.
// RULE12: The open-drain stage drives low during reset and is undriven otherwise.
// RULE13: Supply dips shorter than about 4 us do not cause a reset.
// RULE14: Host software should set and clear the kick at separate program points.
// RULE15: Reset is held for the hold period after supply recovery or watchdog expiry, then the watchdog restarts at zero.
// RULE16: The active pull-up turns on above the trigger level until the line is high or a 2 us one-shot expires.
// RULE17: Watchdog and hold periods are counters on the internal clock with per-option terminal counts.
//
`timescale 1ns/1ps
`default_nettype none
module svwdr_top import svwdr_pkg::*; #(
  parameter logic [TIMER_W-1:0] WATCHDOG_CYCLES = TIMER_W'(WATCHDOG_PERIOD_CYCLES),
  parameter logic [TIMER_W-1:0] HOLD_CYCLES = TIMER_W'(RESET_HOLD_CYCLES),
  parameter logic [1:0] OUTPUT_STAGE = STAGE_PP_LOW
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_kick,
  input wire logic i_kick_floating,
  input wire logic i_supply_low,
  input wire logic i_line_above_trigger,
  input wire logic i_line_high,
  output logic o_reset,
  output logic o_reset_n,
  output logic o_reset_line_out,
  output logic o_reset_line_oe,
  output logic o_passive_pullup_en,
  output logic o_active_pullup_en,
  output logic o_supervisor_reset
);
  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning.
  logic mr_level;
  logic kick_level;
  logic kick_change;
  logic float_level;
  logic supply_low_level;
  logic line_above;
  logic line_high;
  logic line_above_prev;

  // Short manual reset lows are swallowed by the filter. [RULE3]
  svwdr_filter #(.CYCLES(MR_GLITCH_CYCLES), .RESET_LEVEL(1'b1)) u_mr (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_manual_reset_n),
    .o_level(mr_level), .o_change());
  // Kick pulses of at least the minimum width plus one cycle produce one change per edge. [RULE5]
  svwdr_filter #(.CYCLES(KICK_MIN_CYCLES), .RESET_LEVEL(1'b0)) u_kick (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_watchdog_kick),
    .o_level(kick_level), .o_change(kick_change));
  // The float detector is a slow status, so simple synchronisation suffices.
  svwdr_filter #(.CYCLES(1), .RESET_LEVEL(1'b0)) u_float (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_kick_floating),
    .o_level(float_level), .o_change());
  // Supply dips shorter than the reject time never reach the sequencer. [RULE13]
  svwdr_filter #(.CYCLES(DIP_REJECT_CYCLES), .RESET_LEVEL(1'b1)) u_supply (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_supply_low),
    .o_level(supply_low_level), .o_change());
  svwdr_filter #(.CYCLES(1), .RESET_LEVEL(1'b1)) u_above (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_line_above_trigger),
    .o_level(line_above), .o_change());
  svwdr_filter #(.CYCLES(1), .RESET_LEVEL(1'b1)) u_high (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_line_high),
    .o_level(line_high), .o_change());

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer.
  svwdr_state_t state;
  logic [TIMER_W-1:0] hold_count;
  logic [TIMER_W-1:0] wd_count;
  logic [TIMER_W-1:0] service_count;
  logic wd_expired;
  logic force_reset;

  assign force_reset = !mr_level || supply_low_level || wd_expired; // [RULE1] [RULE4]
  assign wd_expired = (state == SVWDR_RUN) && (wd_count >= WATCHDOG_CYCLES - TIMER_W'(1)); // [RULE4]

  // Any source re-enters assert; hold is counted only once all sources are gone.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= SVWDR_ASSERT;
      hold_count <= '0;
    end else begin
      unique case (state)
        SVWDR_ASSERT: begin
          hold_count <= '0;
          if (!force_reset) begin
            state <= SVWDR_HOLD; // [RULE1]
          end
        end
        SVWDR_HOLD: begin
          if (force_reset) begin
            state <= SVWDR_ASSERT;
            hold_count <= '0;
          end else if (hold_count >= HOLD_CYCLES - TIMER_W'(1)) begin
            state <= SVWDR_RUN; // [RULE2] [RULE15] [RULE17]
          end else begin
            hold_count <= hold_count + TIMER_W'(1);
          end
        end
        SVWDR_RUN: begin
          if (force_reset) begin
            state <= SVWDR_ASSERT;
          end
        end
        default: begin
          state <= SVWDR_ASSERT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog timer.
  logic service_pulse;
  assign service_pulse = float_level && (service_count >= ((WATCHDOG_CYCLES >> 3) * TIMER_W'(7)) - TIMER_W'(1));

  // Internal servicing at seven eighths of the period when the kick floats. [RULE7] [RULE8]
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      service_count <= '0;
    end else if (state != SVWDR_RUN || !float_level || service_pulse) begin
      service_count <= '0;
    end else begin
      service_count <= service_count + TIMER_W'(1);
    end
  end

  // Cleared during reset and on any kick edge; restarts from zero on release. [RULE5] [RULE6] [RULE15]
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wd_count <= '0;
    end else if (state != SVWDR_RUN || kick_change || service_pulse) begin
      wd_count <= '0;
    end else begin
      wd_count <= wd_count + TIMER_W'(1); // [RULE17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage.
  logic asserting;
  logic [TIMER_W-1:0] shot_count;
  logic armed;
  assign asserting = (state != SVWDR_RUN);

  // Push-pull outputs follow the sequencer; open-drain and bidirectional only pull low.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reset <= 1'b1;
      o_reset_n <= 1'b0;
      o_supervisor_reset <= 1'b1;
      o_reset_line_out <= 1'b0;
      o_reset_line_oe <= 1'b1;
      o_passive_pullup_en <= 1'b0;
    end else begin
      o_reset <= asserting;
      o_reset_n <= !asserting;
      o_supervisor_reset <= asserting;
      o_reset_line_out <= 1'b0; // [RULE12]
      o_reset_line_oe <= asserting && (OUTPUT_STAGE == STAGE_OPEN_DRAIN || OUTPUT_STAGE == STAGE_BIDIR); // [RULE12]
      o_passive_pullup_en <= (OUTPUT_STAGE == STAGE_BIDIR) && !asserting; // [RULE11]
    end
  end

  // Arms on any low line, whoever pulled it, and fires the pull-up on rise. [RULE9] [RULE10] [RULE16]
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      line_above_prev <= 1'b1;
      armed <= 1'b0;
      shot_count <= '0;
      o_active_pullup_en <= 1'b0;
    end else begin
      line_above_prev <= line_above;
      if (OUTPUT_STAGE != STAGE_BIDIR) begin
        armed <= 1'b0;
        o_active_pullup_en <= 1'b0;
      end else if (!line_above) begin
        armed <= 1'b1; // [RULE9]
        o_active_pullup_en <= 1'b0;
      end else if (armed && !line_above_prev && !asserting) begin
        armed <= 1'b0;
        shot_count <= '0;
        o_active_pullup_en <= !line_high; // [RULE16]
      end else if (o_active_pullup_en) begin
        shot_count <= shot_count + TIMER_W'(1);
        if (line_high || asserting || shot_count >= TIMER_W'(PULLUP_SHOT_CYCLES - 1)) begin
          o_active_pullup_en <= 1'b0; // [RULE10] [RULE16]
        end
      end
    end
  end
endmodule : svwdr_top
`default_nettype wire

// [bench/svwdr_monitor.sv]
// Port checker of the supervisory reset block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module svwdr_monitor import svwdr_pkg::*; #(
  parameter logic [TIMER_W-1:0] WATCHDOG_CYCLES = 32'h190,
  parameter logic [TIMER_W-1:0] HOLD_CYCLES = 32'h32
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_kick,
  input wire logic i_kick_floating,
  input wire logic i_supply_low,
  input wire logic i_line_above_trigger,
  input wire logic i_line_high,
  input wire logic o_reset,
  input wire logic o_reset_n,
  input wire logic o_reset_line_out,
  input wire logic o_reset_line_oe,
  input wire logic o_passive_pullup_en,
  input wire logic o_active_pullup_en,
  input wire logic o_supervisor_reset
);
  logic [31:0] mr_run, mr_hi, idle, sup;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////
  // Run lengths of each cause; idle restarts on a kick change, a float or any reset.
  always_ff @(posedge i_clock) begin
    mr_run <= !i_reset_n ? '0 : i_manual_reset_n ? mr_run : (mr_hi != '0 ? 32'h1 : mr_run + 32'h1);
    mr_hi <= (!i_reset_n || !i_manual_reset_n) ? '0 : mr_hi + 32'h1;
    idle <= (o_reset || i_kick_floating || $changed(i_watchdog_kick)) ? '0 : idle + 32'h1;
    sup <= (!i_reset_n || !i_supply_low) ? '0 : sup + 32'h1;
  end
  // The trigger only matters on a released line that is still below its high level.
  sequence line_rise_s;
    !o_reset && !i_line_high ##1 $rose(i_line_above_trigger);
  endsequence
  out_polarity_a: assert property (o_reset_n == !o_reset && o_supervisor_reset == o_reset)
    else $error("Reset outputs disagree.");
  mr_assert_a: assert property (!i_manual_reset_n && mr_run > 32'h1a |-> o_reset)
    else $error("Manual reset low without reset.");
  hold_time_a: assert property ($fell(o_reset) |-> mr_hi >= HOLD_CYCLES)
    else $error("Reset released before the hold period.");
  reset_cause_a: assert property ($rose(o_reset) |->
      (mr_run > 32'h11 && mr_hi < 32'h8) || sup > 32'h315 || idle + 32'h8 >= WATCHDOG_CYCLES)
    else $error("Reset raised without a cause.");
  wd_expire_a: assert property (idle <= WATCHDOG_CYCLES + 32'h20)
    else $error("Watchdog did not expire.");
  line_drive_a: assert property (o_reset_line_oe == o_reset && !o_reset_line_out)
    else $error("Reset line drive wrong.");
  pullup_off_a: assert property (o_reset |-> !o_passive_pullup_en)
    else $error("Passive pull-up on during reset.");
  active_on_a: assert property (line_rise_s |-> ##[1:6] o_active_pullup_en)
    else $error("Active pull-up missed the rising line.");
endmodule : svwdr_monitor
bind svwdr_top svwdr_monitor #(.WATCHDOG_CYCLES(WATCHDOG_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) svwdr_monitor_i (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_manual_reset_n(i_manual_reset_n),
  .i_watchdog_kick(i_watchdog_kick), .i_kick_floating(i_kick_floating), .i_supply_low(i_supply_low),
  .i_line_above_trigger(i_line_above_trigger), .i_line_high(i_line_high), .o_reset(o_reset),
  .o_reset_n(o_reset_n), .o_reset_line_out(o_reset_line_out), .o_reset_line_oe(o_reset_line_oe),
  .o_passive_pullup_en(o_passive_pullup_en), .o_active_pullup_en(o_active_pullup_en),
  .o_supervisor_reset(o_supervisor_reset));
`default_nettype wire

// [bench/svwdr_host_model.sv]
// Behavioural host: reset line charge model and watchdog kick driver.
`timescale 1ns/1ps
`default_nettype none
module svwdr_host_model (
  input wire logic i_clock,
  input wire logic i_oe,
  input wire logic i_pass,
  input wire logic i_act,
  input wire logic i_low,
  input wire logic i_run,
  input wire logic i_drive,
  output logic o_above,
  output logic o_high,
  output logic o_kick,
  output logic o_float
);
  logic [4:0] lvl = 5'h0;
  logic [6:0] cnt = 7'h0;
  logic kick_q = 1'b0;
  // Any pull-down empties the line; the resistor charges it slowly, the active pull-up fast.
  always @(posedge i_clock) begin
    if (i_oe || i_low) lvl <= 5'h0;
    else if (i_act) lvl <= (lvl > 5'h17) ? 5'h1f : lvl + 5'h8;
    else if (i_pass && lvl != 5'h1f) lvl <= lvl + 5'h1;
  end
  // The kick is set and later cleared, never pulsed, so a stuck loop lets it expire.
  always @(posedge i_clock) begin
    if (i_run) cnt <= (cnt == 7'h63) ? 7'h0 : cnt + 7'h1;
    if (i_run && cnt == 7'h63) kick_q <= ~kick_q;
  end
  // A released kick pin has no pull, so it shows the inverse of its last level.
  assign o_kick = i_drive ? kick_q : ~kick_q;
  assign o_float = !i_drive;
  assign o_above = lvl >= 5'h4;
  assign o_high = lvl >= 5'h18;
endmodule : svwdr_host_model
`default_nettype wire

// [bench/svwdr_top_tb.sv]
// Self-checking bench of the supervisory reset block with the bidirectional stage.
`timescale 1ns/1ps
`default_nettype none
module svwdr_top_tb;
  logic i_clock = 1'b0, i_reset_n = 1'b0, i_manual_reset_n = 1'b1, i_supply_low = 1'b0;
  logic ext_low = 1'b0, run = 1'b1, drive = 1'b1;
  logic i_watchdog_kick, i_kick_floating, i_line_above_trigger, i_line_high, o_reset, o_reset_n;
  logic o_reset_line_out, o_reset_line_oe, o_passive_pullup_en, o_active_pullup_en, o_supervisor_reset;
  int err_count = 0;
  int comparisons = 0;
  // Short counts keep the run brief; waits below are scaled from 400 and 50.
  svwdr_top #(.WATCHDOG_CYCLES(32'h190), .HOLD_CYCLES(32'h32), .OUTPUT_STAGE(2'h3)) svwdr_top_i (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_manual_reset_n(i_manual_reset_n),
    .i_watchdog_kick(i_watchdog_kick), .i_kick_floating(i_kick_floating), .i_supply_low(i_supply_low),
    .i_line_above_trigger(i_line_above_trigger), .i_line_high(i_line_high), .o_reset(o_reset),
    .o_reset_n(o_reset_n), .o_reset_line_out(o_reset_line_out), .o_reset_line_oe(o_reset_line_oe),
    .o_passive_pullup_en(o_passive_pullup_en), .o_active_pullup_en(o_active_pullup_en),
    .o_supervisor_reset(o_supervisor_reset));
  svwdr_host_model svwdr_host_model_i (.i_clock(i_clock), .i_oe(o_reset_line_oe), .i_pass(o_passive_pullup_en),
    .i_act(o_active_pullup_en), .i_low(ext_low), .i_run(run), .i_drive(drive), .o_above(i_line_above_trigger),
    .o_high(i_line_high), .o_kick(i_watchdog_kick), .o_float(i_kick_floating));
  ////////////////////////////////////////
  always #2.5 i_clock = ~i_clock;
  // A hang is cut short at about twice the planned run.
  initial begin
    repeat (12000) @(posedge i_clock);
    err_count++;
    end_sim();
  end
  task automatic end_sim();
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic check(input logic v, input logic e);
    comparisons++;
    if (v !== e) begin
      err_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, v, e);
    end
  endtask : check
  // Inputs move 1 ns after the edge, where outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick
  task automatic wait_rst(input logic e, input int n);
    for (int k = 0; k < n && o_reset !== e; k++) tick(1);
    check(o_reset, e);
  endtask : wait_rst
  task automatic stay(input logic e, input int n);
    repeat (n) begin
      tick(1);
      check(o_reset, e);
    end
  endtask : stay
  // The resistor alone needs 24 cycles, so 14 proves the active pull-up.
  task automatic line_up();
    for (int k = 0; k < 14 && i_line_high !== 1'b1; k++) tick(1);
    check(i_line_high, 1'b1);
  endtask : line_up
  task automatic t_boot();
    check(o_reset, 1'b1);
    // The supply filter leaves reset as if the supply were low, so boot waits out its reject time too.
    wait_rst(1'b0, 900);
    line_up();
  endtask : t_boot
  task automatic t_mr();
    i_manual_reset_n = 1'b0;
    tick(12);
    i_manual_reset_n = 1'b1;
    stay(1'b0, 40);
    i_manual_reset_n = 1'b0;
    wait_rst(1'b1, 40);
    stay(1'b1, 60);
    i_manual_reset_n = 1'b1;
    stay(1'b1, 50);
    wait_rst(1'b0, 40);
    line_up();
  endtask : t_mr
  task automatic t_wd();
    run = 1'b0;
    stay(1'b0, 250);
    wait_rst(1'b1, 250);
    wait_rst(1'b0, 80);
    stay(1'b0, 380);
    wait_rst(1'b1, 60);
    run = 1'b1;
    wait_rst(1'b0, 80);
    stay(1'b0, 1000);
  endtask : t_wd
  // The host loop is stopped as well, so only the internal service can keep the watchdog quiet.
  task automatic t_float();
    run = 1'b0;
    drive = 1'b0;
    stay(1'b0, 1200);
    drive = 1'b1;
    run = 1'b1;
  endtask : t_float
  task automatic t_sup();
    i_supply_low = 1'b1;
    tick(300);
    i_supply_low = 1'b0;
    stay(1'b0, 100);
    i_supply_low = 1'b1;
    wait_rst(1'b1, 900);
    tick(20);
    i_supply_low = 1'b0;
    stay(1'b1, 50);
    wait_rst(1'b0, 900);
  endtask : t_sup
  task automatic t_ext();
    ext_low = 1'b1;
    tick(10);
    check(o_active_pullup_en, 1'b0);
    ext_low = 1'b0;
    line_up();
  endtask : t_ext
  initial begin
    tick(2);
    i_reset_n = 1'b1;
    t_boot();
    t_mr();
    t_wd();
    t_float();
    t_sup();
    t_ext();
    end_sim();
  end
endmodule : svwdr_top_tb
`default_nettype wire
